// ### core/fpc_pkg.sv
// Package with register map, field layout and timing counts of the flash control.
package fpc_pkg;
  // Register offsets in the special-function area.
  localparam logic [7:0] STATUS_OFF = 8'heb;
  localparam logic [7:0] TLIMIT_OFF = 8'hec;
  localparam logic [7:0] ADDRH_OFF = 8'hf2;
  localparam logic [7:0] ADDRM_OFF = 8'hf3;
  localparam logic [7:0] ADDRL_OFF = 8'hf4;
  localparam logic [7:0] DATA_OFF = 8'hf5;
  localparam logic [7:0] CTRL_OFF = 8'hf6;
  // Reset values.
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [7:0] TLIMIT_RST = 8'h00;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] CTRL_PULSE_RST = 6'h03;
  // Control register fields.
  localparam int CTRL_BULK = 7;
  localparam int CTRL_EXIT_HI = 5;
  localparam int CTRL_EXIT_LO = 4;
  localparam int CTRL_WRITE = 3;
  localparam int CTRL_READ = 2;
  localparam int CTRL_LRST = 1;
  localparam int CTRL_PBRST = 0;
  // Status register fields.
  localparam int STAT_CRCSEL = 5;
  localparam int STAT_VPASS = 6;
  localparam int STAT_IRQ = 3;
  // Mode register fields, as driven by the mode register block.
  localparam int MODE_PGM = 5;
  localparam int MODE_ERASE = 4;
  localparam int MODE_PBUF = 3;
  localparam int MODE_VFY = 1;
  localparam int MODE_EN = 0;
  // Program-mode entry pair.
  localparam logic [7:0] ENTRY_FIRST = 8'ha5;
  localparam logic [7:0] ENTRY_SECOND = 8'h5a;
  // Timing and geometry.
  localparam int PRESCALE = 128;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_AW = 6;
  localparam int TCNT_W = 10;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PE = 2'b01,
    ST_VREQ = 2'b10,
    ST_VCHK = 2'b11
  } fpc_state_t;
endpackage

// ### core/fpc_page_buf.sv
// Page buffer memory with one-clock clear of all entries and registered read data.
`timescale 1ns/100ps
module fpc_page_buf #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Clear all entries
  input wire logic clr,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [(1<<AW)-1:0] valid_reg;

  // A cleared entry reads as erased cells, so no sweep over the array is
  // needed and the clear takes one clock.
  always_ff @(posedge clk) begin
    if (!rst_b || clr) begin
      valid_reg <= '0;
    end else if (we) begin
      valid_reg[waddr] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (valid_reg[raddr] && !(we && waddr == raddr)) begin
      rdata <= mem[raddr];
    end else if (valid_reg[raddr]) begin
      rdata <= wdata;
    end else begin
      rdata <= {DW{1'b1}};
    end
  end
endmodule

// ### core/fpc_flash_ctrl.sv
// Flash program, erase and verify controller behind the SFR port.
// Notes on behaviour
// - Done flag clears on start, sets on end.
// - Readback select picks checksum or CRC.
// - Interrupt flag sets on end, clears on start.
// - Ten-bit timer ticks every 128 clocks.
// - Timer stops when count matches limit.
// - Page operation lasts (limit+1)*2*128 clocks.
// - Bulk erase lasts (limit+1)*4*128 clocks.
// - Program and erase use page-aligned address.
// - Verify increments address, reports pass flag.
// - Address registers write-only; reads give results.
// - Outside modes, start bits move one byte.
// - Data writes A5 then 5A enter program mode.
// - Write and read starts self-clear after one clock.
// - Buffer reset clears buffer or write checksum.
// - Indirect addressing only for program, erase, verify.
// - 64 Kbyte array, 64-byte pages.
// - Registers reachable only in programming mode.
// - Verify selected by verify bit plus program or erase bit.
`timescale 1ns/100ps
module fpc_flash_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // SFR access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Chip mode and mode register
  input wire logic isp_mode,
  input wire logic [7:0] flash_mode_reg,
  input wire logic [15:0] mc_addr,
  // Flash array
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  output logic fl_we,
  output logic fl_rd,
  input wire logic [7:0] fl_rdata,
  output logic fl_prog,
  output logic fl_erase,
  output logic fl_bulk,
  // Status
  output logic prog_mode,
  output logic flash_irq
);
  fpc_pkg::fpc_state_t state_reg;
  logic [7:0] time_limit_reg;
  logic [23:0] addr_reg;
  logic [7:0] data_reg;
  logic bulk_erase_enable;
  logic [5:0] ctl_pulse_reg;
  logic op_done_flag;
  logic verify_pass_flag;
  logic crc_readback_select;
  logic seen_first_reg;
  logic [6:0] presc_reg;
  logic [fpc_pkg::TCNT_W-1:0] tcnt_reg;
  logic [fpc_pkg::TCNT_W-1:0] lim_reg;
  logic [fpc_pkg::PAGE_AW-1:0] vcnt_reg;
  logic [fpc_pkg::PAGE_AW-1:0] ptr_reg;
  logic vf_prog_reg;
  logic [23:0] chk_reg;
  logic [15:0] crc_reg;
  logic byte_rd_reg;
  logic byte_pb_reg;
  logic [7:0] pb_rdata;
  logic [17:0] dur_reg;
  logic acc, wr_status, wr_tl, wr_data, wr_ctl;
  logic go_w, go_r, logic_rst, pb_rst, do_exit;
  logic write_mode_flag, erase_mode_flag, verify_mode_flag, page_buf_select;
  logic any_mode, idle, pe_start, vf_start, tick, pe_fin, vf_fin;
  logic pb_we, pb_clr;
  logic [fpc_pkg::PAGE_AW-1:0] pb_raddr;
  logic [7:0] vbyte;

  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ fpc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Register access gate
  assign acc = isp_mode;
  assign wr_status = sfr_wr && acc && sfr_addr == fpc_pkg::STATUS_OFF;
  assign wr_tl = sfr_wr && acc && sfr_addr == fpc_pkg::TLIMIT_OFF;
  assign wr_data = sfr_wr && acc && sfr_addr == fpc_pkg::DATA_OFF;
  assign wr_ctl = sfr_wr && acc && sfr_addr == fpc_pkg::CTRL_OFF;

  // Control actions act one clock after the write, from the pulse register.
  assign go_w = ctl_pulse_reg[fpc_pkg::CTRL_WRITE];
  assign go_r = ctl_pulse_reg[fpc_pkg::CTRL_READ];
  assign logic_rst = !ctl_pulse_reg[fpc_pkg::CTRL_LRST];
  assign pb_rst = !ctl_pulse_reg[fpc_pkg::CTRL_PBRST];
  assign do_exit = ctl_pulse_reg[fpc_pkg::CTRL_EXIT_HI] &&
                   ctl_pulse_reg[fpc_pkg::CTRL_EXIT_LO];

  assign verify_mode_flag = flash_mode_reg[fpc_pkg::MODE_VFY] &&
                            (flash_mode_reg[fpc_pkg::MODE_PGM] ||
                             flash_mode_reg[fpc_pkg::MODE_ERASE]);
  assign write_mode_flag = flash_mode_reg[fpc_pkg::MODE_EN] &&
                           flash_mode_reg[fpc_pkg::MODE_PGM] &&
                           !flash_mode_reg[fpc_pkg::MODE_VFY];
  assign erase_mode_flag = flash_mode_reg[fpc_pkg::MODE_EN] &&
                           flash_mode_reg[fpc_pkg::MODE_ERASE] &&
                           !flash_mode_reg[fpc_pkg::MODE_VFY];
  assign page_buf_select = flash_mode_reg[fpc_pkg::MODE_PBUF];
  assign any_mode = write_mode_flag || erase_mode_flag || verify_mode_flag;

  // starts, indirect only in these modes
  assign idle = state_reg == fpc_pkg::ST_IDLE;
  assign pe_start = idle && go_w && prog_mode && !logic_rst &&
                    (write_mode_flag || erase_mode_flag);
  assign vf_start = idle && go_r && prog_mode && !logic_rst &&
                    verify_mode_flag;
  assign tick = presc_reg == 7'(fpc_pkg::PRESCALE - 1);
  assign pe_fin = state_reg == fpc_pkg::ST_PE && tick && tcnt_reg == lim_reg;
  assign vf_fin = state_reg == fpc_pkg::ST_VCHK &&
                  vcnt_reg == fpc_pkg::PAGE_AW'(fpc_pkg::PAGE_BYTES - 1);

  assign pb_we = idle && go_w && !any_mode && page_buf_select;
  assign pb_clr = pb_rst && !page_buf_select;
  assign pb_raddr = (state_reg == fpc_pkg::ST_VREQ) ? vcnt_reg : ptr_reg;
  assign vbyte = fl_rdata;

  fpc_page_buf #(
    .AW(fpc_pkg::PAGE_AW),
    .DW(8)
  ) u_page_buf (
    .clk(clk),
    .rst_b(rst_b),
    .clr(pb_clr),
    .we(pb_we),
    .waddr(ptr_reg),
    .wdata(data_reg),
    .raddr(pb_raddr),
    .rdata(pb_rdata)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_pulse_reg <= fpc_pkg::CTRL_PULSE_RST;
      bulk_erase_enable <= 1'b0;
    end else if (wr_ctl) begin
      ctl_pulse_reg <= sfr_wdata[5:0];
      bulk_erase_enable <= sfr_wdata[fpc_pkg::CTRL_BULK];
    end else begin
      ctl_pulse_reg <= fpc_pkg::CTRL_PULSE_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seen_first_reg <= 1'b0;
      prog_mode <= 1'b0;
    end else begin
      if (wr_data) begin
        seen_first_reg <= sfr_wdata == fpc_pkg::ENTRY_FIRST;
      end
      if (do_exit) begin
        prog_mode <= 1'b0;
      end else if (wr_data && seen_first_reg &&
                   sfr_wdata == fpc_pkg::ENTRY_SECOND) begin
        prog_mode <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      time_limit_reg <= fpc_pkg::TLIMIT_RST;
    end else if (wr_tl) begin
      time_limit_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_reg <= fpc_pkg::ADDR_RST;
    end else if (state_reg == fpc_pkg::ST_VCHK) begin
      addr_reg <= addr_reg + 24'h000001;
    end else if (sfr_wr && acc) begin
      case (sfr_addr)
        fpc_pkg::ADDRH_OFF: addr_reg[23:16] <= sfr_wdata;
        fpc_pkg::ADDRM_OFF: addr_reg[15:8] <= sfr_wdata;
        fpc_pkg::ADDRL_OFF: addr_reg[7:0] <= sfr_wdata;
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  // byte read lands in the data register two clocks after the read start pulse.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_reg <= fpc_pkg::DATA_RST;
      byte_rd_reg <= 1'b0;
      byte_pb_reg <= 1'b0;
      ptr_reg <= '0;
    end else begin
      byte_rd_reg <= idle && go_r && !any_mode;
      byte_pb_reg <= page_buf_select;
      if (wr_data) begin
        data_reg <= sfr_wdata;
      end else if (byte_rd_reg) begin
        data_reg <= byte_pb_reg ? pb_rdata : fl_rdata;
      end
      if (pb_clr) begin
        ptr_reg <= '0;
      end else if (pb_we || (byte_rd_reg && byte_pb_reg)) begin
        ptr_reg <= ptr_reg + 1'b1;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clk) begin
    if (!rst_b || logic_rst) begin
      state_reg <= fpc_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        fpc_pkg::ST_IDLE: begin
          if (pe_start) begin
            state_reg <= fpc_pkg::ST_PE;
          end else if (vf_start) begin
            state_reg <= fpc_pkg::ST_VREQ;
          end
        end
        fpc_pkg::ST_PE: begin
          if (pe_fin) begin
            state_reg <= fpc_pkg::ST_IDLE;
          end
        end
        fpc_pkg::ST_VREQ: state_reg <= fpc_pkg::ST_VCHK;
        fpc_pkg::ST_VCHK: begin
          state_reg <= vf_fin ? fpc_pkg::ST_IDLE : fpc_pkg::ST_VREQ;
        end
        default: state_reg <= fpc_pkg::ST_IDLE;
      endcase
    end
  end

  // timer zeroed at start, page and bulk limits, bulk
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      presc_reg <= '0;
      tcnt_reg <= '0;
      lim_reg <= '0;
    end else if (pe_start) begin
      presc_reg <= '0;
      tcnt_reg <= '0;
      lim_reg <= (erase_mode_flag && bulk_erase_enable) ?
                 {time_limit_reg, 2'b11} : {1'b0, time_limit_reg, 1'b1};
    end else if (state_reg == fpc_pkg::ST_PE) begin
      presc_reg <= presc_reg + 7'h01;
      if (tick && !pe_fin) begin
        tcnt_reg <= tcnt_reg + 1'b1;
      end
    end
  end

  // page-aligned address, byte or page access
  always_ff @(posedge clk) begin
    if (!rst_b || logic_rst) begin
      fl_addr <= '0;
      fl_wdata <= '0;
      fl_we <= 1'b0;
      fl_rd <= 1'b0;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_bulk <= 1'b0;
    end else begin
      fl_we <= idle && go_w && !any_mode && !page_buf_select;
      fl_rd <= (idle && go_r && !any_mode && !page_buf_select) ||
               state_reg == fpc_pkg::ST_VREQ;
      if (pe_start) begin
        fl_addr <= {addr_reg[15:fpc_pkg::PAGE_AW], 6'h00};
        fl_prog <= write_mode_flag;
        fl_erase <= erase_mode_flag && !bulk_erase_enable;
        fl_bulk <= erase_mode_flag && bulk_erase_enable;
      end else if (pe_fin) begin
        fl_prog <= 1'b0;
        fl_erase <= 1'b0;
        fl_bulk <= 1'b0;
      end else if (state_reg == fpc_pkg::ST_VREQ) begin
        fl_addr <= addr_reg[15:0];
      end else if (idle && (go_w || go_r) && !any_mode) begin
        fl_addr <= mc_addr;
        fl_wdata <= data_reg;
      end
    end
  end

  // compare against buffer or erased value, with checksum and CRC
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vcnt_reg <= '0;
      vf_prog_reg <= 1'b0;
      chk_reg <= '0;
      crc_reg <= fpc_pkg::CRC_INIT;
    end else if (vf_start) begin
      vcnt_reg <= '0;
      vf_prog_reg <= flash_mode_reg[fpc_pkg::MODE_PGM];
      chk_reg <= '0;
      crc_reg <= fpc_pkg::CRC_INIT;
    end else if (state_reg == fpc_pkg::ST_VCHK) begin
      vcnt_reg <= vcnt_reg + 1'b1;
      chk_reg <= chk_reg + {16'h0000, vbyte};
      crc_reg <= crc_step(crc_reg, vbyte);
    end else if (pb_rst && page_buf_select) begin
      chk_reg <= '0;
    end else if (pb_we) begin
      chk_reg <= chk_reg + {16'h0000, data_reg};
    end
  end

  // done flag, interrupt flag; hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      op_done_flag <= fpc_pkg::STATUS_RST[7];
      verify_pass_flag <= fpc_pkg::STATUS_RST[fpc_pkg::STAT_VPASS];
      crc_readback_select <= fpc_pkg::STATUS_RST[fpc_pkg::STAT_CRCSEL];
      flash_irq <= fpc_pkg::STATUS_RST[fpc_pkg::STAT_IRQ];
    end else begin
      if (wr_status) begin
        crc_readback_select <= sfr_wdata[fpc_pkg::STAT_CRCSEL];
      end
      if (pe_fin || vf_fin || logic_rst) begin
        op_done_flag <= 1'b1;
      end else if (pe_start || vf_start) begin
        op_done_flag <= 1'b0;
      end
      if (pe_fin || vf_fin) begin
        flash_irq <= 1'b1;
      end else if (pe_start || vf_start) begin
        flash_irq <= 1'b0;
      end else if (wr_status) begin
        flash_irq <= sfr_wdata[fpc_pkg::STAT_IRQ];
      end
      if (vf_start) begin
        verify_pass_flag <= 1'b1;
      end else if (state_reg == fpc_pkg::ST_VCHK &&
                   vbyte != (vf_prog_reg ? pb_rdata : fpc_pkg::ERASED_BYTE)) begin
        verify_pass_flag <= 1'b0;
      end else if (wr_status) begin
        verify_pass_flag <= sfr_wdata[fpc_pkg::STAT_VPASS];
      end
    end
  end

  // readback; reads outside programming mode return zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfr_rdata <= '0;
    end else if (sfr_rd) begin
      case (acc ? sfr_addr : 8'h00)
        fpc_pkg::STATUS_OFF: sfr_rdata <= {op_done_flag, verify_pass_flag,
          crc_readback_select, 1'b0, flash_irq, write_mode_flag,
          erase_mode_flag, verify_mode_flag};
        fpc_pkg::TLIMIT_OFF: sfr_rdata <= time_limit_reg;
        fpc_pkg::ADDRH_OFF:
          sfr_rdata <= crc_readback_select ? 8'h00 : chk_reg[23:16];
        fpc_pkg::ADDRM_OFF:
          sfr_rdata <= crc_readback_select ? crc_reg[15:8] : chk_reg[15:8];
        fpc_pkg::ADDRL_OFF:
          sfr_rdata <= crc_readback_select ? crc_reg[7:0] : chk_reg[7:0];
        fpc_pkg::DATA_OFF: sfr_rdata <= data_reg;
        fpc_pkg::CTRL_OFF: sfr_rdata <= {bulk_erase_enable, 1'b0, ctl_pulse_reg};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Cycles spent in the timed state, for checking only.
  always_ff @(posedge clk) begin
    if (!rst_b || pe_start) begin
      dur_reg <= '0;
    end else if (state_reg == fpc_pkg::ST_PE) begin
      dur_reg <= dur_reg + 18'h00001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_done_clr;
    (pe_start || vf_start) |=> !op_done_flag ##1 !op_done_flag;
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done flag not cleared at start");

  property p_irq_set;
    (pe_fin || vf_fin) |=> flash_irq && op_done_flag && idle;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("irq or done flag not set at end");

  property p_tmr_zero;
    pe_start |=> tcnt_reg == 10'h000 && presc_reg == 7'h00 && !op_done_flag;
  endproperty
  a_tmr_zero: assert property (p_tmr_zero)
    else $error("timer not zeroed at start");

  property p_page_len;
    pe_fin && !fl_bulk |->
      dur_reg + 18'h00001 == (18'(lim_reg) + 18'h00001) * 18'h00080 &&
      lim_reg == {1'b0, time_limit_reg, 1'b1};
  endproperty
  a_page_len: assert property (p_page_len)
    else $error("page operation length wrong");

  property p_bulk_len;
    pe_fin && fl_bulk |->
      dur_reg + 18'h00001 == (18'(lim_reg[9:2]) + 18'h00001) * 18'h00200;
  endproperty
  a_bulk_len: assert property (p_bulk_len)
    else $error("bulk erase length wrong");

  property p_page_addr;
    (fl_prog || fl_erase) |-> fl_addr[5:0] == 6'h00;
  endproperty
  a_page_addr: assert property (p_page_addr)
    else $error("program address not page aligned");

  property p_vf_inc;
    state_reg == fpc_pkg::ST_VCHK |=> addr_reg == $past(addr_reg) + 24'h000001;
  endproperty
  a_vf_inc: assert property (p_vf_inc)
    else $error("verify address did not advance");

  property p_entry;
    wr_data && sfr_wdata == fpc_pkg::ENTRY_FIRST ##1 !wr_data ##1
      wr_data && sfr_wdata == fpc_pkg::ENTRY_SECOND && !do_exit |=> prog_mode;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry pair did not enter program mode");

  property p_exit;
    do_exit |=> !prog_mode;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit code did not leave program mode");

  property p_selfclr;
    wr_ctl && sfr_wdata[fpc_pkg::CTRL_WRITE] ##1 !wr_ctl |=>
      !ctl_pulse_reg[fpc_pkg::CTRL_WRITE];
  endproperty
  a_selfclr: assert property (p_selfclr)
    else $error("write start did not self-clear");
endmodule

// ### tb/fpc_flash_model.sv
// Behavioural flash array answering the controller's cell strobes.
`timescale 1ns/100ps
module fpc_flash_model (
  // Clock
  input wire logic clk,
  // Cell port
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_we,
  input wire logic fl_rd,
  output logic [7:0] fl_rdata,
  // Timed operations
  input wire logic fl_erase,
  input wire logic fl_bulk
);
  logic [7:0] mem [0:65535];
  logic [15:0] pg = 16'h0000;
  logic er_q = 1'b0;
  logic bulk_q = 1'b0;
  logic [7:0] junk_q = 8'h3c;
  // Cells start off non-erased, except where the low address byte is c3, so a verify cannot pass by luck.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h3c;
  end
  // The controller takes read data at the end of its read strobe, so the
  // array answers within that cycle; outside a strobe the data toggles so a
  // sample taken at the wrong time cannot match.
  assign fl_rdata = fl_rd ? mem[fl_addr] : junk_q;
  // byte access, erase by page or whole array
  always @(posedge clk) begin
    if (fl_we) mem[fl_addr] <= fl_wdata;
    junk_q <= ~junk_q;
    er_q <= fl_erase | fl_bulk;
    if (fl_erase | fl_bulk) pg <= fl_addr;
    if (fl_erase | fl_bulk) bulk_q <= fl_bulk;
    if (er_q && !(fl_erase | fl_bulk))
      for (int i = 0; i < 65536; i++)
        if (bulk_q || i[15:6] == pg[15:6]) mem[i] <= 8'hff;
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the flash program, erase and verify controller.
`timescale 1ns/100ps
module tb_top;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;}
    fpc_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic isp_mode = 1'b1;
  logic [7:0] flash_mode_reg = 8'h00;
  logic [15:0] mc_addr = 16'h1250;
  logic [15:0] fl_addr;
  logic [7:0] fl_wdata, fl_rdata, v;
  logic fl_we, fl_rd, fl_prog, fl_erase, fl_bulk, prog_mode, flash_irq;
  logic [15:0] last_a, pe_a;
  int err_total = 0;
  int n_compared = 0;
  int busy_n = 0;
  int rd_n = 0;
  fpc_row_t rows [6] = '{
    '{1'b0, fpc_pkg::STATUS_OFF, 8'h00, 8'h80},
    '{1'b0, fpc_pkg::TLIMIT_OFF, 8'h00, 8'h00},
    '{1'b0, fpc_pkg::CTRL_OFF, 8'h00, 8'h03},
    '{1'b0, 8'he0, 8'h00, 8'h00},
    '{1'b1, fpc_pkg::TLIMIT_OFF, 8'h8f, 8'h8f},
    '{1'b1, fpc_pkg::TLIMIT_OFF, 8'h01, 8'h01}};

  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (fl_erase | fl_prog | fl_bulk) begin
      busy_n <= busy_n + 1;
      pe_a <= fl_addr;
    end
    if (fl_rd) begin
      rd_n <= rd_n + 1;
      last_a <= fl_addr;
    end
  end

  fpc_flash_ctrl dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .isp_mode(isp_mode),
    .flash_mode_reg(flash_mode_reg), .mc_addr(mc_addr), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_we(fl_we), .fl_rd(fl_rd), .fl_rdata(fl_rdata),
    .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_bulk(fl_bulk),
    .prog_mode(prog_mode), .flash_irq(flash_irq));

  fpc_flash_model model (.clk(clk), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_we(fl_we), .fl_rd(fl_rd), .fl_rdata(fl_rdata),
    .fl_erase(fl_erase), .fl_bulk(fl_bulk));

  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    d = sfr_rdata;
  endtask

  // idle then poll
  // One idle cycle after a start, then status is polled until done.
  task automatic poll(output logic [7:0] s);
    @(posedge clk);
    for (int i = 0; i < 400; i++) begin
      rd(fpc_pkg::STATUS_OFF, s);
      if (s[7] === 1'b1) break;
    end
  endtask

  task automatic op(input logic [7:0] c, input int n);
    int b0;
    b0 = busy_n;
    wr(fpc_pkg::CTRL_OFF, c);
    rd(fpc_pkg::STATUS_OFF, v);
    chk("busy", {v[7], v[3]}, 2'b00);
    chk("mode flags", v[2:0], 3'b010);
    poll(v);
    chk("done", {v[7], v[3]}, 2'b11);
    chk("irq", flash_irq, 1'b1);
    chk("cycles", 16'(busy_n - b0), 16'(n));
  endtask

  task automatic verify_select(input logic pass);
    int r0;
    r0 = rd_n;
    wr(fpc_pkg::ADDRL_OFF, 8'h40);
    @(posedge clk) flash_mode_reg <= 8'h13;
    wr(fpc_pkg::CTRL_OFF, 8'h07);
    poll(v);
    chk("verify", {v[7], v[6], v[3], v[0]}, {1'b1, pass, 2'b11});
    chk("reads", 16'(rd_n - r0), 16'd64);
    chk("last addr", last_a, 16'h127f);
    $display("verify test done");
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("row", v, rows[i].e);
    end
    $display("register rows done");
    @(posedge clk) isp_mode <= 1'b0;
    wr(fpc_pkg::TLIMIT_OFF, 8'h55);
    rd(fpc_pkg::TLIMIT_OFF, v);
    chk("gated read", v, 8'h00);
    @(posedge clk) isp_mode <= 1'b1;
    rd(fpc_pkg::TLIMIT_OFF, v);
    chk("gated write", v, 8'h01);
    $display("gating test done");
    wr(fpc_pkg::DATA_OFF, 8'ha5);
    wr(fpc_pkg::DATA_OFF, 8'h00);
    wr(fpc_pkg::DATA_OFF, 8'h5a);
    repeat (2) @(negedge clk);
    chk("broken entry", prog_mode, 1'b0);
    wr(fpc_pkg::DATA_OFF, 8'ha5);
    wr(fpc_pkg::DATA_OFF, 8'h5a);
    repeat (2) @(negedge clk);
    chk("entry", prog_mode, 1'b1);
    $display("entry test done");
    wr(fpc_pkg::ADDRH_OFF, 8'h00);
    wr(fpc_pkg::ADDRM_OFF, 8'h12);
    wr(fpc_pkg::TLIMIT_OFF, 8'h02);
    verify_select(1'b0);
    @(posedge clk) flash_mode_reg <= 8'h11;
    wr(fpc_pkg::ADDRL_OFF, 8'h47);
    op(8'h0b, 768);
    chk("page addr", pe_a, 16'h1240);
    $display("page erase test done");
    verify_select(1'b1);
    rd(fpc_pkg::ADDRM_OFF, v);
    chk("checksum mid", v, 8'h3f);
    rd(fpc_pkg::ADDRL_OFF, v);
    chk("checksum low", v, 8'hc0);
    @(posedge clk) flash_mode_reg <= 8'h00;
    wr(fpc_pkg::DATA_OFF, 8'h12);
    wr(fpc_pkg::CTRL_OFF, 8'h0b);
    wr(fpc_pkg::DATA_OFF, 8'h00);
    wr(fpc_pkg::CTRL_OFF, 8'h07);
    @(posedge clk);
    rd(fpc_pkg::DATA_OFF, v);
    chk("byte move", v, 8'h12);
    $display("byte move test done");
    verify_select(1'b0);
    @(posedge clk) flash_mode_reg <= 8'h11;
    wr(fpc_pkg::TLIMIT_OFF, 8'h00);
    op(8'h8b, 512);
    $display("bulk erase test done");
    wr(fpc_pkg::CTRL_OFF, 8'h13);
    repeat (3) @(negedge clk);
    chk("no exit", prog_mode, 1'b1);
    wr(fpc_pkg::CTRL_OFF, 8'h33);
    repeat (3) @(negedge clk);
    chk("exit", prog_mode, 1'b0);
    rd(fpc_pkg::CTRL_OFF, v);
    chk("ctrl restore", v, 8'h03);
    $display("exit test done");
    test_done;
  end
endmodule
